// ### logic/srrs_consts.vh
// Constants for the safety reset release sequencer
`ifndef SRRS_CONSTS_VH
`define SRRS_CONSTS_VH

// ----------------------------------------
// Timing
// ----------------------------------------
`define SRRS_CLK_PERIOD_NS      10
`define SRRS_RESET_HOLD_US      100
`define SRRS_RESET_HOLD_CYC     ((`SRRS_RESET_HOLD_US * 1000) / `SRRS_CLK_PERIOD_NS)
`define SRRS_QA_TIMEOUT_CYC     4096

// ----------------------------------------
// Reset cause codes
// ----------------------------------------
`define SRRS_CAUSE_W            3
`define SRRS_CAUSE_NONE         3'h0
`define SRRS_CAUSE_RAM          3'h1
`define SRRS_CAUSE_ROM          3'h2
`define SRRS_CAUSE_OTHER        3'h3

// ----------------------------------------
// Reset counter, exchange steps and converter test
// ----------------------------------------
`define SRRS_CNT_W              4
`define SRRS_MAX_RESETS         4'h3
`define SRRS_QA_STEPS           3'h4
`define SRRS_ADC_W              12
`define SRRS_ADC_TOL            12'h020
`define SRRS_ADC_GRAD_MAX       12'h200
`define SRRS_ADC_OFS_TOL        12'h040

`endif

// ### logic/srrs_adc_check.v
// Converter fault test: gradient, offset, stuck register, dual-converter compare
`timescale 1ns/1ns
`include "srrs_consts.vh"
module srrs_adc_check #(
	parameter ADC_W    = `SRRS_ADC_W,
	parameter DUAL_ADC = 1
) (
	// Clock and reset
	input  wire             clk,
	input  wire             rst,
	// Converter samples
	input  wire             smp_vld,
	input  wire [ADC_W-1:0] smp_a,
	input  wire [ADC_W-1:0] smp_b,
	input  wire [ADC_W-1:0] ref_val,
	input  wire             chan_sw,
	// Results
	output reg              grad_err_q,
	output reg              ofs_err_q,
	output reg              stuck_err_q,
	output reg              cmp_err_q
);

function [ADC_W-1:0] absdiff;
	input [ADC_W-1:0] a;
	input [ADC_W-1:0] b;
	begin
		absdiff = (a > b) ? (a - b) : (b - a);
	end
endfunction

reg [ADC_W-1:0] last_q;
reg             seen_q;

always @(posedge clk or posedge rst) begin
	if (rst) begin
		last_q      <= {ADC_W{1'b0}};
		seen_q      <= 1'b0;
		grad_err_q  <= 1'b0;
		ofs_err_q   <= 1'b0;
		stuck_err_q <= 1'b0;
		cmp_err_q   <= 1'b0;
	end else if (smp_vld) begin
		last_q <= smp_a;
		seen_q <= 1'b1;
		// Sticky: a cleared error would mask an intermittent converter
		if (seen_q && !chan_sw && absdiff(smp_a, last_q) > `SRRS_ADC_GRAD_MAX) begin
			grad_err_q <= 1'b1;
		end
		if (absdiff(smp_a, ref_val) > `SRRS_ADC_OFS_TOL && !chan_sw) begin
			ofs_err_q <= 1'b1;
		end
		// Channel switched but result unchanged: mux or register stuck
		if (seen_q && chan_sw && smp_a == last_q) begin
			stuck_err_q <= 1'b1;
		end
		if (DUAL_ADC != 0 && absdiff(smp_a, smp_b) > `SRRS_ADC_TOL) begin
			cmp_err_q <= 1'b1;
		end
	end
end

endmodule

// ### logic/srrs_top.v
// Safety reset release sequencer top level
// Function
// - Safety reset drives supervisor and main processor resets together.
// - Power output stages forced off while reset is active.
// - Reset hold duration is a module parameter.
// - Stored software reset cause is evaluated before start authorization.
// - Memory failure cause requires passing memory recheck before release.
// - Unlocalized memory failure requires whole-memory recheck.
// - Software resets per driving cycle counted against configurable maximum.
// - Exceeding reset limit keeps power stages currentless until restart.
// - Question/answer exchange resynchronises supervisor and processor after reset.
// - Shut-off path tests coupled to exchange, reporting each path.
// - Power stages released only after successful shut-off path test.
// - Monitoring fault reactions stay latched across safety reset.
// - Converter test finds gradient, offset and stuck register faults.
// - Non-analog pedal sensors use spare converter channel for testing in the single converter variant (DUAL_ADC = 0).
// - Dual converter variant samples one signal on both and compares.
// - Second pedal sensor preferred for dual converter comparison.
// - Engine run authorized only after each controller's path test passes.
// - Failed power-latch path test forces new test at next initialization.
`timescale 1ns/1ns
`include "srrs_consts.vh"
module srrs_top #(
	parameter RESET_HOLD_CYC = `SRRS_RESET_HOLD_CYC,
	parameter QA_TIMEOUT_CYC = `SRRS_QA_TIMEOUT_CYC,
	parameter ADC_W          = `SRRS_ADC_W,
	parameter DUAL_ADC       = 1,
	parameter PEDAL_ANALOG   = 1
) (
	// Clock and power-on reset
	input  wire                    REF_CLK,
	input  wire                    RST,
	// Reset requests and driving cycle
	input  wire                    SW_RESET_REQ,
	input  wire [`SRRS_CAUSE_W-1:0] SW_RESET_CAUSE,
	input  wire                    MEM_LOCALIZED,
	input  wire                    NEW_DRIVE_CYCLE,
	input  wire [`SRRS_CNT_W-1:0]  MAX_RESETS,
	input  wire                    MON_FAULT,
	// Memory recheck
	output wire                    MEM_CHECK_REQ,
	output reg                     MEM_CHECK_FULL_Q,
	input  wire                    MEM_CHECK_DONE,
	input  wire                    MEM_CHECK_PASS,
	// Question/answer exchange
	output reg                     QA_QUESTION_Q,
	input  wire                    QA_ANSWER_OK,
	input  wire                    QA_ANSWER_BAD,
	// Shut-off path test
	output reg                     SUP_PATH_TEST_Q,
	output reg                     MAIN_PATH_TEST_Q,
	input  wire                    SUP_PATH_OFF,
	input  wire                    MAIN_PATH_OFF,
	input  wire                    POWER_LATCH_TEST_FAIL,
	output reg                     SUP_PATH_OK_Q,
	output reg                     MAIN_PATH_OK_Q,
	// Converter samples
	input  wire                    ADC_VLD,
	input  wire [ADC_W-1:0]        ADC_A_PEDAL1,
	input  wire [ADC_W-1:0]        ADC_A_PEDAL2,
	input  wire [ADC_W-1:0]        ADC_A_SPARE,
	input  wire [ADC_W-1:0]        ADC_B_PEDAL2,
	input  wire [ADC_W-1:0]        ADC_REF,
	input  wire                    ADC_CHAN_SW,
	output wire [3:0]              ADC_FAULT,
	// Resets and release
	output reg                     SUPERVISOR_UNIT_RST_Q,
	output reg                     MAIN_FUNCTION_PROCESSOR_RST_Q,
	output reg                     STAGES_OFF_Q,
	output reg                     OUTPUT_RELEASE_Q,
	output reg                     ENGINE_RUN_AUTH_Q,
	output reg                     SHUTOFF_LATCH_Q,
	output reg                     MON_FAULT_LATCH_Q,
	output reg  [`SRRS_CNT_W-1:0]  RESET_COUNT_Q,
	output reg  [2:0]              STATE_Q
);

// ----------------------------------------
// States
// ----------------------------------------
localparam ST_HOLD  = 3'h0;
localparam ST_CAUSE = 3'h1;
localparam ST_MEM   = 3'h2;
localparam ST_QA    = 3'h3;
localparam ST_PATH  = 3'h4;
localparam ST_RUN   = 3'h5;
localparam ST_SHUT  = 3'h6;

// ----------------------------------------
// Input synchronisers
// ----------------------------------------
// Reset request and drive cycle pins pass three flops; second and third must agree
reg [2:0] req_s;
reg [2:0] ndc_s;
reg       req_lvl_q;
reg       ndc_lvl_q;
reg       req_prev_q;
reg       ndc_prev_q;

always @(posedge REF_CLK or posedge RST) begin
	if (RST) begin
		req_s      <= 3'h0;
		ndc_s      <= 3'h0;
		req_lvl_q  <= 1'b0;
		ndc_lvl_q  <= 1'b0;
		req_prev_q <= 1'b0;
		ndc_prev_q <= 1'b0;
	end else begin
		req_s <= {req_s[1:0], SW_RESET_REQ};
		ndc_s <= {ndc_s[1:0], NEW_DRIVE_CYCLE};
		if (req_s[1] == req_s[2]) begin
			req_lvl_q <= req_s[2];
		end
		if (ndc_s[1] == ndc_s[2]) begin
			ndc_lvl_q <= ndc_s[2];
		end
		req_prev_q <= req_lvl_q;
		ndc_prev_q <= ndc_lvl_q;
	end
end

wire sw_reset_evt = req_lvl_q & ~req_prev_q;
wire new_cycle    = ndc_lvl_q & ~ndc_prev_q;

// ----------------------------------------
// Converter test
// ----------------------------------------
wire [ADC_W-1:0] adc_test_a = (PEDAL_ANALOG != 0) ? ADC_A_PEDAL1 : ADC_A_SPARE;
wire [ADC_W-1:0] adc_cmp_a  = ADC_A_PEDAL2;
wire             grad_err;
wire             ofs_err;
wire             stuck_err;
wire             cmp_err;

srrs_adc_check #(
	.ADC_W    (ADC_W),
	.DUAL_ADC (DUAL_ADC)
) u_adc (
	.clk         (REF_CLK),
	.rst         (RST),
	.smp_vld     (ADC_VLD),
	.smp_a       ((DUAL_ADC != 0) ? adc_cmp_a : adc_test_a),
	.smp_b       (ADC_B_PEDAL2),
	.ref_val     (ADC_REF),
	.chan_sw     (ADC_CHAN_SW),
	.grad_err_q  (grad_err),
	.ofs_err_q   (ofs_err),
	.stuck_err_q (stuck_err),
	.cmp_err_q   (cmp_err)
);

assign ADC_FAULT = {cmp_err, stuck_err, ofs_err, grad_err};

// ----------------------------------------
// Sequencer
// ----------------------------------------
reg [31:0]              hold_cnt_q;
reg [31:0]              qa_cnt_q;
reg [2:0]               qa_step_q;
reg [`SRRS_CAUSE_W-1:0] cause_q;
reg                     mem_ok_q;
reg                     retest_q;
reg                     mem_req_q;

assign MEM_CHECK_REQ = mem_req_q;

wire limit_hit = (RESET_COUNT_Q > MAX_RESETS);
wire mem_cause = (cause_q == `SRRS_CAUSE_RAM) || (cause_q == `SRRS_CAUSE_ROM);
wire release_ok = SUP_PATH_OK_Q & MAIN_PATH_OK_Q & mem_ok_q & ~SHUTOFF_LATCH_Q
	& ~MON_FAULT_LATCH_Q & ~retest_q;

always @(posedge REF_CLK or posedge RST) begin
	if (RST) begin
		STATE_Q                       <= ST_HOLD;
		hold_cnt_q                    <= 32'h0;
		qa_cnt_q                      <= 32'h0;
		qa_step_q                     <= 3'h0;
		cause_q                       <= `SRRS_CAUSE_NONE;
		mem_ok_q                      <= 1'b0;
		retest_q                      <= 1'b0;
		mem_req_q                     <= 1'b0;
		MEM_CHECK_FULL_Q              <= 1'b0;
		QA_QUESTION_Q                 <= 1'b0;
		SUP_PATH_TEST_Q               <= 1'b0;
		MAIN_PATH_TEST_Q              <= 1'b0;
		SUP_PATH_OK_Q                 <= 1'b0;
		MAIN_PATH_OK_Q                <= 1'b0;
		SUPERVISOR_UNIT_RST_Q         <= 1'b1;
		MAIN_FUNCTION_PROCESSOR_RST_Q <= 1'b1;
		STAGES_OFF_Q                  <= 1'b1;
		OUTPUT_RELEASE_Q              <= 1'b0;
		ENGINE_RUN_AUTH_Q             <= 1'b0;
		SHUTOFF_LATCH_Q               <= 1'b0;
		MON_FAULT_LATCH_Q             <= 1'b0;
		RESET_COUNT_Q                 <= {`SRRS_CNT_W{1'b0}};
	end else begin
		// Power latch failure forces a fresh test at next init
		if (POWER_LATCH_TEST_FAIL) begin
			retest_q <= 1'b1;
		end
		// Latched faults survive the safety reset; only power-on clears them
		if (MON_FAULT) begin
			MON_FAULT_LATCH_Q <= 1'b1;
		end
		// Counter cleared by new driving cycle only; new reset wins on collision
		if (sw_reset_evt) begin
			if (RESET_COUNT_Q != {`SRRS_CNT_W{1'b1}}) begin
				RESET_COUNT_Q <= RESET_COUNT_Q + 1'b1;
			end
		end else if (new_cycle) begin
			RESET_COUNT_Q <= {`SRRS_CNT_W{1'b0}};
		end
		case (STATE_Q)
		ST_HOLD: begin
			SUPERVISOR_UNIT_RST_Q         <= 1'b1;
			MAIN_FUNCTION_PROCESSOR_RST_Q <= 1'b1;
			STAGES_OFF_Q                  <= 1'b1;
			OUTPUT_RELEASE_Q              <= 1'b0;
			ENGINE_RUN_AUTH_Q             <= 1'b0;
			if (hold_cnt_q >= RESET_HOLD_CYC - 1) begin
				hold_cnt_q                    <= 32'h0;
				SUPERVISOR_UNIT_RST_Q         <= 1'b0;
				MAIN_FUNCTION_PROCESSOR_RST_Q <= 1'b0;
				STATE_Q                       <= ST_CAUSE;
			end else begin
				hold_cnt_q <= hold_cnt_q + 32'h1;
			end
		end
		ST_CAUSE: begin
			if (limit_hit) begin
				SHUTOFF_LATCH_Q <= 1'b1;
				STATE_Q         <= ST_SHUT;
			end else if (mem_cause) begin
				mem_ok_q         <= 1'b0;
				mem_req_q        <= 1'b1;
				MEM_CHECK_FULL_Q <= ~MEM_LOCALIZED;
				STATE_Q          <= ST_MEM;
			end else begin
				mem_ok_q  <= 1'b1;
				qa_step_q <= 3'h0;
				qa_cnt_q  <= 32'h0;
				STATE_Q   <= ST_QA;
			end
		end
		ST_MEM: begin
			if (MEM_CHECK_DONE) begin
				mem_req_q <= 1'b0;
				if (MEM_CHECK_PASS) begin
					mem_ok_q  <= 1'b1;
					cause_q   <= `SRRS_CAUSE_NONE;
					qa_step_q <= 3'h0;
					qa_cnt_q  <= 32'h0;
					STATE_Q   <= ST_QA;
				end else begin
					// Re-entry asserts both resets now so the hold runs its full length
					SUPERVISOR_UNIT_RST_Q         <= 1'b1;
					MAIN_FUNCTION_PROCESSOR_RST_Q <= 1'b1;
					STATE_Q                       <= ST_HOLD;
				end
			end
		end
		ST_QA: begin
			QA_QUESTION_Q <= 1'b1;
			qa_cnt_q      <= qa_cnt_q + 32'h1;
			if (QA_ANSWER_BAD || qa_cnt_q >= QA_TIMEOUT_CYC - 1) begin
				QA_QUESTION_Q                 <= 1'b0;
				SUPERVISOR_UNIT_RST_Q         <= 1'b1;
				MAIN_FUNCTION_PROCESSOR_RST_Q <= 1'b1;
				STATE_Q                       <= ST_HOLD;
			end else if (QA_ANSWER_OK) begin
				qa_cnt_q  <= 32'h0;
				qa_step_q <= qa_step_q + 3'h1;
				// Path tests ride on the exchange: one per processor
				if (qa_step_q == 3'h1) begin
					SUP_PATH_TEST_Q <= 1'b1;
				end
				if (qa_step_q == 3'h2) begin
					SUP_PATH_TEST_Q  <= 1'b0;
					SUP_PATH_OK_Q    <= SUP_PATH_OFF;
					MAIN_PATH_TEST_Q <= 1'b1;
				end
				if (qa_step_q == `SRRS_QA_STEPS - 3'h1) begin
					MAIN_PATH_TEST_Q <= 1'b0;
					MAIN_PATH_OK_Q   <= MAIN_PATH_OFF;
					// Only a full passing test clears a pending retest; a held fail request wins
					if (SUP_PATH_OK_Q && MAIN_PATH_OFF && !POWER_LATCH_TEST_FAIL) begin
						retest_q <= 1'b0;
					end
					QA_QUESTION_Q    <= 1'b0;
					STATE_Q          <= ST_PATH;
				end
			end
		end
		ST_PATH: begin
			if (release_ok) begin
				retest_q          <= 1'b0;
				STAGES_OFF_Q      <= 1'b0;
				OUTPUT_RELEASE_Q  <= 1'b1;
				ENGINE_RUN_AUTH_Q <= 1'b1;
				STATE_Q           <= ST_RUN;
			end else if (MON_FAULT_LATCH_Q) begin
				STATE_Q <= ST_SHUT;
			end else begin
				SUPERVISOR_UNIT_RST_Q         <= 1'b1;
				MAIN_FUNCTION_PROCESSOR_RST_Q <= 1'b1;
				STATE_Q                       <= ST_HOLD;
			end
		end
		ST_RUN: begin
			if (sw_reset_evt) begin
				cause_q           <= SW_RESET_CAUSE;
				SUP_PATH_OK_Q     <= 1'b0;
				MAIN_PATH_OK_Q    <= 1'b0;
				STAGES_OFF_Q      <= 1'b1;
				OUTPUT_RELEASE_Q  <= 1'b0;
				ENGINE_RUN_AUTH_Q <= 1'b0;
				hold_cnt_q        <= 32'h0;
				// Both processors enter reset together with the stages switching off
				SUPERVISOR_UNIT_RST_Q         <= 1'b1;
				MAIN_FUNCTION_PROCESSOR_RST_Q <= 1'b1;
				STATE_Q           <= ST_HOLD;
			end else if (MON_FAULT) begin
				STAGES_OFF_Q      <= 1'b1;
				OUTPUT_RELEASE_Q  <= 1'b0;
				ENGINE_RUN_AUTH_Q <= 1'b0;
				STATE_Q           <= ST_SHUT;
			end
		end
		ST_SHUT: begin
			// Only a power-on reset leaves this state
			STAGES_OFF_Q      <= 1'b1;
			OUTPUT_RELEASE_Q  <= 1'b0;
			ENGINE_RUN_AUTH_Q <= 1'b0;
		end
		default: begin
			STATE_Q <= ST_HOLD;
		end
		endcase
	end
end

endmodule

// ### testbench/srrs_checker_asserts.sv
// Port-level property checker for the safety reset release sequencer
`timescale 1ns/1ns
module srrs_checker #(
	parameter RESET_HOLD_CYC = 8
) (
	// Clock and reset
	input wire       REF_CLK,
	input wire       RST,
	// Watched ports
	input wire       NEW_DRIVE_CYCLE,
	input wire       MON_FAULT,
	input wire       MEM_CHECK_REQ,
	input wire       QA_QUESTION_Q,
	input wire       SUP_PATH_OK_Q,
	input wire       MAIN_PATH_OK_Q,
	input wire       SUPERVISOR_UNIT_RST_Q,
	input wire       MAIN_FUNCTION_PROCESSOR_RST_Q,
	input wire       STAGES_OFF_Q,
	input wire       OUTPUT_RELEASE_Q,
	input wire       ENGINE_RUN_AUTH_Q,
	input wire       SHUTOFF_LATCH_Q,
	input wire       MON_FAULT_LATCH_Q,
	input wire [3:0] RESET_COUNT_Q
);
	reg [15:0] hold_q;
	// Saturates so a stuck reset cannot wrap into the legal window
	always @(posedge REF_CLK or posedge RST) begin
		if (RST)
			hold_q <= 16'h0000;
		else if (!SUPERVISOR_UNIT_RST_Q)
			hold_q <= 16'h0000;
		else if (hold_q != 16'hffff)
			hold_q <= hold_q + 16'h0001;
	end
	default clocking @(posedge REF_CLK); endclocking
	default disable iff (RST);
	// ----------------------------------------
	// Properties
	// ----------------------------------------
	property p_rst_pair;
		SUPERVISOR_UNIT_RST_Q == MAIN_FUNCTION_PROCESSOR_RST_Q;
	endproperty
	a_rst_pair: assert property (p_rst_pair) else $error("resets differ");
	property p_stages;
		SUPERVISOR_UNIT_RST_Q |-> STAGES_OFF_Q;
	endproperty
	a_stages: assert property (p_stages) else $error("stages on in reset");
	property p_hold;
		$fell(SUPERVISOR_UNIT_RST_Q) |-> hold_q inside {[RESET_HOLD_CYC:RESET_HOLD_CYC+2]};
	endproperty
	a_hold: assert property (p_hold) else $error("hold length wrong");
	property p_release;
		$rose(OUTPUT_RELEASE_Q) |-> SUP_PATH_OK_Q && MAIN_PATH_OK_Q && !SHUTOFF_LATCH_Q && !SUPERVISOR_UNIT_RST_Q;
	endproperty
	a_release: assert property (p_release) else $error("early release");
	property p_auth;
		$rose(ENGINE_RUN_AUTH_Q) |-> SUP_PATH_OK_Q && MAIN_PATH_OK_Q;
	endproperty
	a_auth: assert property (p_auth) else $error("early run grant");
	property p_shut;
		SHUTOFF_LATCH_Q |=> SHUTOFF_LATCH_Q && STAGES_OFF_Q && !OUTPUT_RELEASE_Q;
	endproperty
	a_shut: assert property (p_shut) else $error("shut-off not held");
	property p_mon;
		(MON_FAULT || MON_FAULT_LATCH_Q) |=> MON_FAULT_LATCH_Q;
	endproperty
	a_mon: assert property (p_mon) else $error("fault latch lost");
	property p_count;
		!NEW_DRIVE_CYCLE [*8] |=> RESET_COUNT_Q >= $past(RESET_COUNT_Q);
	endproperty
	a_count: assert property (p_count) else $error("count dropped");
	property p_qa;
		$rose(QA_QUESTION_Q) |-> ##[1:200] !QA_QUESTION_Q;
	endproperty
	a_qa: assert property (p_qa) else $error("exchange hangs");
	c_release: cover property ($rose(OUTPUT_RELEASE_Q));
	c_shutoff: cover property ($rose(SHUTOFF_LATCH_Q));
	c_mem: cover property ($rose(MEM_CHECK_REQ));
endmodule
bind srrs_top srrs_checker #(.RESET_HOLD_CYC(RESET_HOLD_CYC)) u_srrs_chk (.*);

// ### testbench/srrs_far_model.sv
// Behavioural model of the supervisor and main processor side
`timescale 1ns/1ns
module srrs_far_model (
	// Clock and reset
	input  wire       clk,
	input  wire       rst,
	// Requests from the sequencer
	input  wire       question,
	input  wire       mem_req,
	input  wire       sup_test,
	input  wire       main_test,
	// Scenario knobs
	input  wire [3:0] gap,
	input  wire       bad_ans,
	input  wire       mem_ok,
	input  wire [1:0] path_ok,
	// Answers
	output reg        ans_ok_q,
	output reg        ans_bad_q,
	output wire       mem_done,
	output wire       mem_pass,
	output wire       sup_off,
	output wire       main_off
);
	reg [3:0] qa_cnt_q;
	reg [1:0] mem_cnt_q;
	reg       junk_q;
	// Gap of f stays mute so the sequencer must time out
	always @(posedge clk or posedge rst) begin
		if (rst) begin
			qa_cnt_q <= 4'h0;
			ans_ok_q <= 1'b0;
			ans_bad_q <= 1'b0;
		end else begin
			ans_ok_q <= 1'b0;
			ans_bad_q <= 1'b0;
			if (!question)
				qa_cnt_q <= 4'h0;
			else if (gap != 4'hf && qa_cnt_q >= gap) begin
				qa_cnt_q <= 4'h0;
				ans_ok_q <= !bad_ans;
				ans_bad_q <= bad_ans;
			end else
				qa_cnt_q <= qa_cnt_q + 4'h1;
		end
	end
	// Idle lines toggle so a stale level is never mistaken for an answer
	always @(posedge clk or posedge rst) begin
		if (rst) begin
			mem_cnt_q <= 2'h0;
			junk_q <= 1'b0;
		end else begin
			junk_q <= !junk_q;
			mem_cnt_q <= !mem_req ? 2'h0 : (mem_cnt_q == 2'h3) ? mem_cnt_q : mem_cnt_q + 2'h1;
		end
	end
	assign mem_done = mem_req && mem_cnt_q == 2'h3;
	assign mem_pass = mem_req ? mem_ok : junk_q;
	assign sup_off = sup_test ? path_ok[0] : junk_q;
	assign main_off = main_test ? path_ok[1] : junk_q;
endmodule

// ### testbench/srrs_tb_top.sv
// Self-checking testbench for the safety reset release sequencer
`timescale 1ns/1ns
module srrs_tb_top;
	logic        REF_CLK = 0, RST = 1, SW_RESET_REQ = 0, MEM_LOCALIZED = 0, NEW_DRIVE_CYCLE = 0;
	logic        MON_FAULT = 0, POWER_LATCH_TEST_FAIL = 0, ADC_VLD = 0, ADC_CHAN_SW = 0;
	logic [2:0]  SW_RESET_CAUSE = 0;
	logic [3:0]  MAX_RESETS = 4'hf, gap = 4'h1;
	logic [11:0] ADC_A_PEDAL1 = 0, ADC_A_PEDAL2 = 0, ADC_A_SPARE = 0, ADC_B_PEDAL2 = 0, ADC_REF = 0;
	logic        bad_ans = 0, mem_ok = 1, got, req, full, ss, sm, q;
	logic [1:0]  path_ok = 2'b11;
	wire         MEM_CHECK_REQ, MEM_CHECK_FULL_Q, MEM_CHECK_DONE, MEM_CHECK_PASS, QA_QUESTION_Q;
	wire         QA_ANSWER_OK, QA_ANSWER_BAD, SUP_PATH_TEST_Q, MAIN_PATH_TEST_Q, SUP_PATH_OFF, MAIN_PATH_OFF;
	wire         SUP_PATH_OK_Q, MAIN_PATH_OK_Q, SUPERVISOR_UNIT_RST_Q, MAIN_FUNCTION_PROCESSOR_RST_Q;
	wire         STAGES_OFF_Q, OUTPUT_RELEASE_Q, ENGINE_RUN_AUTH_Q, SHUTOFF_LATCH_Q, MON_FAULT_LATCH_Q;
	wire [3:0]   ADC_FAULT, RESET_COUNT_Q;
	wire [2:0]   STATE_Q;
	int          fail_count = 0, checks = 0, cycles = 0;
	srrs_top #(.RESET_HOLD_CYC(8), .QA_TIMEOUT_CYC(50)) i_dut (.*);
	srrs_far_model i_far (.clk(REF_CLK), .rst(RST), .question(QA_QUESTION_Q), .mem_req(MEM_CHECK_REQ),
		.sup_test(SUP_PATH_TEST_Q), .main_test(MAIN_PATH_TEST_Q), .gap(gap), .bad_ans(bad_ans),
		.mem_ok(mem_ok), .path_ok(path_ok), .ans_ok_q(QA_ANSWER_OK), .ans_bad_q(QA_ANSWER_BAD),
		.mem_done(MEM_CHECK_DONE), .mem_pass(MEM_CHECK_PASS), .sup_off(SUP_PATH_OFF), .main_off(MAIN_PATH_OFF));
	always #5 REF_CLK = ~REF_CLK;
	// Whole run needs about 1500 cycles
	always @(posedge REF_CLK) begin
		cycles++;
		if (cycles == 6000) begin
			fail_count++;
			summarize;
		end
	end
	task automatic summarize;
		if (fail_count == 0 && checks > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask
	task automatic chk(input logic [3:0] got_v, input logic [3:0] exp_v);
		checks++;
		if (got_v !== exp_v) begin
			fail_count++;
			$display("unexpected at %0t: got %h expected %h", $time, got_v, exp_v);
		end
	endtask
	// Sticky fault word {cmp,stuck,offset,gradient} after each corner sample
	function automatic logic [3:0] adc_exp(input int j);
		case (j)
			0: adc_exp = 4'h0;
			1: adc_exp = 4'h4;
			2: adc_exp = 4'h5;
			default: adc_exp = 4'h7;
		endcase
	endfunction
	task automatic step(input int n);
		repeat (n) @(posedge REF_CLK);
		#1;
	endtask
	// Cause stays put until the next request; the sequencer reads it unsynchronised, late, on the synchronised request
	task automatic sw_reset(input logic [2:0] cause);
		SW_RESET_CAUSE = cause;
		SW_RESET_REQ = 1;
		step(3);
		SW_RESET_REQ = 0;
		step(8);
	endtask
	task automatic wait_rel;
		got = 0;
		req = 0;
		full = 0;
		for (int i = 0; i < 400 && !got; i++) begin
			step(1);
			if (MEM_CHECK_REQ === 1'b1) begin
				req = 1;
				full = MEM_CHECK_FULL_Q;
			end
			got = OUTPUT_RELEASE_Q;
		end
	endtask
	// ----------------------------------------
	// Main sequence
	// ----------------------------------------
	initial begin
		void'($urandom(32'h36400dd6));
		step(12);
		chk({SUPERVISOR_UNIT_RST_Q, MAIN_FUNCTION_PROCESSOR_RST_Q, STAGES_OFF_Q, OUTPUT_RELEASE_Q}, 4'he);
		RST = 0;
		for (int i = 0; i < 24; i++) begin
			ADC_A_PEDAL2 = 12'($urandom_range(0, 12'hef0));
			ADC_B_PEDAL2 = ADC_A_PEDAL2 + 12'((i == 23) ? 12'h100 : $urandom_range(0, 8));
			ADC_A_PEDAL1 = ADC_A_PEDAL2 ^ 12'h800;
			ADC_A_SPARE = 12'($urandom);
			ADC_REF = 12'($urandom);
			ADC_CHAN_SW = i[0];
			ADC_VLD = 1;
			step(1);
			ADC_VLD = 0;
			step(2);
			if (i >= 22)
				chk(ADC_FAULT[3], i == 23);
		end
		wait_rel;
		chk({got, ENGINE_RUN_AUTH_Q, SUP_PATH_OK_Q, MAIN_PATH_OK_Q}, 4'hf);
		chk({STAGES_OFF_Q, SHUTOFF_LATCH_Q}, 0);
		for (int k = 0; k < 4; k++) begin
			gap = 4'($urandom_range(1, 3));
			MEM_LOCALIZED = k[0];
			sw_reset(3'(k + 1));
			wait_rel;
			chk({got, req, full}, {1'b1, k < 2, k == 0});
			chk(RESET_COUNT_Q, 4'(k + 1));
		end
		POWER_LATCH_TEST_FAIL = 1;
		for (int f = 0; f < 5; f++) begin
			mem_ok = (f != 0);
			bad_ans = (f == 1);
			gap = (f == 2) ? 4'hf : 4'h1;
			path_ok = (f == 3) ? 2'b01 : (f == 4) ? 2'b10 : 2'b11;
			sw_reset(3'h1);
			{got, ss, sm} = 0;
			for (int n = 0; n < 90; n++) begin
				q = QA_QUESTION_Q;
				step(1);
				if (q && !QA_QUESTION_Q)
					{ss, sm} = {SUP_PATH_OK_Q, MAIN_PATH_OK_Q};
				got |= OUTPUT_RELEASE_Q;
			end
			chk(got, 0);
			if (f == 3)
				chk({ss, sm}, 2'b10);
			if (f == 4)
				chk(ss, 0);
		end
		{mem_ok, bad_ans, gap, path_ok} = {2'b10, 4'h1, 2'b11};
		step(60);
		chk(OUTPUT_RELEASE_Q, 0);
		POWER_LATCH_TEST_FAIL = 0;
		wait_rel;
		chk(got, 1);
		NEW_DRIVE_CYCLE = 1;
		step(3);
		NEW_DRIVE_CYCLE = 0;
		step(8);
		chk(RESET_COUNT_Q, 0);
		MAX_RESETS = 4'($urandom_range(1, 3));
		for (int n = 1; n <= MAX_RESETS + 1; n++) begin
			sw_reset(0);
			wait_rel;
			chk({got, SHUTOFF_LATCH_Q}, {n <= MAX_RESETS, n > MAX_RESETS});
		end
		NEW_DRIVE_CYCLE = 1;
		step(3);
		NEW_DRIVE_CYCLE = 0;
		MON_FAULT = 1;
		step(1);
		MON_FAULT = 0;
		sw_reset(0);
		step(40);
		chk({SHUTOFF_LATCH_Q, OUTPUT_RELEASE_Q, MON_FAULT_LATCH_Q}, 3'b101);
		RST = 1;
		step(2);
		RST = 0;
		wait_rel;
		chk({got, SHUTOFF_LATCH_Q, MON_FAULT_LATCH_Q}, 3'b100);
		// Converter corners right after power-on, while the fault bits are clear
		{ADC_A_PEDAL2, ADC_B_PEDAL2, ADC_REF} = {3{12'h100}};
		for (int j = 0; j < 4; j++) begin
			ADC_CHAN_SW = (j == 1);
			if (j == 2)
				{ADC_A_PEDAL2, ADC_B_PEDAL2, ADC_REF} = {3{12'h400}};
			if (j == 3)
				ADC_REF = 12'h000;
			ADC_VLD = 1;
			step(1);
			ADC_VLD = 0;
			step(1);
			chk(ADC_FAULT, adc_exp(j));
		end
		summarize;
	end
endmodule
